// >>> hdl/amer_pkg.sv
// Constants for the auto mute and emergency volume ramp block.
// Assumes a 25 MHz system clock and a register host on Avalon-MM.
package amer_pkg;
	// ------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ------------------------------------------------------------
	localparam logic [6:0] IDX_EMERG = 7'h4f;
	localparam logic [6:0] IDX_MUTE_EN = 7'h50;
	localparam logic [6:0] IDX_MUTE_DLY = 7'h51;
	localparam logic [6:0] IDX_BW = 7'h53;
	localparam logic [6:0] IDX_GAIN = 7'h54;
	localparam logic [6:0] IDX_STATE = 7'h69;
	localparam logic [6:0] IDX_VOL = 7'h6a;
	localparam int unsigned ADDR_W = 9;
	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [7:0] RST_EMERG = 8'h30;
	localparam logic [7:0] RST_MUTE_EN = 8'h07;
	localparam logic [7:0] RST_ZERO = 8'h00;
	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int unsigned EMERG_RATE_LSB = 6;
	localparam int unsigned EMERG_STEP_LSB = 4;
	localparam int unsigned LINK_BIT = 2;
	localparam int unsigned EN_RIGHT_BIT = 1;
	localparam int unsigned EN_LEFT_BIT = 0;
	localparam int unsigned TIME_LEFT_LSB = 4;
	localparam int unsigned TIME_RIGHT_LSB = 0;
	localparam int unsigned BW_LSB = 5;
	localparam int unsigned GAIN_LSB = 0;
	// ------------------------------------------------------------
	// Ramp and timing
	// ------------------------------------------------------------
	localparam logic [1:0] RATE_INSTANT = 2'h3;
	localparam logic [7:0] ATTEN_MUTE = 8'hff;
	// Step per update in half-dB units for codes 00..11
	localparam logic [7:0] STEP_HALF_DB [4] = '{8'h08, 8'h04, 8'h02, 8'h01};
	// Zero-run lengths in microseconds at the reference rate
	localparam longint ZERO_TIME_US [8] = '{11500, 53000, 106500, 266500,
		535000, 1065000, 2665000, 5330000};
	localparam longint REF_RATE_HZ = 96000;
	localparam longint US_PER_S = 1000000;
	localparam int unsigned CNT_W = 20;
	localparam int unsigned SAMPLE_W = 24;
	localparam int unsigned FIFO_DEPTH = 16;
endpackage

// >>> hdl/amer_top.sv
// Auto mute and emergency volume ramp with its sample FIFO.
// Assumes samples and fault inputs synchronous to clock; one
// sample leaves the FIFO per sample period as paced by out_ready.
`timescale 1ns/1ps

// ------------------------------------------------------------
// Sample FIFO
// ------------------------------------------------------------
module amer_fifo #(
	parameter int unsigned WIDTH = 48,
	parameter int unsigned DEPTH = 16
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int unsigned PW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0] wp;
		logic [PW-1:0] rp;
		logic [PW:0] count;
		logic ready;
	} amer_fifo_state_t;
	amer_fifo_state_t s_reg, s_next;
	logic push, pop;

	assign in_ready = s_reg.ready;
	assign out_valid = (s_reg.count != '0);
	assign out_data = s_reg.mem[s_reg.rp];

	always_comb begin
		s_next = s_reg;
		push = in_valid && s_reg.ready;
		pop = out_valid && out_ready;
		if (push) begin
			s_next.mem[s_reg.wp] = in_data;
			s_next.wp = s_reg.wp + 1'b1;
		end
		if (pop)
			s_next.rp = s_reg.rp + 1'b1;
		if (push && !pop)
			s_next.count = s_reg.count + 1'b1;
		else if (pop && !push)
			s_next.count = s_reg.count - 1'b1;
		// Ready is registered so the port comes from a flop
		s_next.ready = (s_next.count != (PW+1)'(DEPTH));
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s_reg <= '0;
			s_reg.ready <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end
endmodule // amer_fifo

// ------------------------------------------------------------
// Top
// ------------------------------------------------------------
module amer_top #(
	parameter longint SAMPLE_RATE_HZ = 96000,
	parameter int unsigned SW = amer_pkg::SAMPLE_W
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [amer_pkg::ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [SW-1:0] in_left,
	input wire logic [SW-1:0] in_right,
	output logic out_valid,
	input wire logic out_ready,
	output logic [SW-1:0] out_left,
	output logic [SW-1:0] out_right,
	input wire logic clock_error,
	input wire logic power_outage,
	output logic mute_left,
	output logic mute_right,
	output logic [7:0] volume_atten,
	output logic [1:0] class_d_bandwidth,
	output logic [4:0] output_attenuation
);
	localparam int unsigned CW = amer_pkg::CNT_W;

	typedef struct packed {
		logic [7:0] emerg;
		logic [7:0] mute_en;
		logic [7:0] mute_dly;
		logic [7:0] bw;
		logic [7:0] gain;
		logic [CW-1:0] cnt_l;
		logic [CW-1:0] cnt_r;
		logic mute_l;
		logic mute_r;
		logic [7:0] atten;
		logic [1:0] rate_cnt;
		logic out_valid;
		logic [SW-1:0] out_l;
		logic [SW-1:0] out_r;
		logic wait_q;
		logic [7:0] rdata;
	} amer_state_t;
	amer_state_t s_reg, s_next;

	logic fifo_valid, pop, emerg, qual_l, qual_r;
	logic [2*SW-1:0] fifo_data;
	logic [6:0] idx;
	logic [1:0] rate;
	logic [7:0] step;
	logic [8:0] sum;

	// Zero-run length in samples; scales with Fs, so time is fixed per code
	function automatic logic [CW-1:0] zero_limit(input logic [2:0] code);
		longint n;
		// Default rate gives the reference counts; lower rates shorten runs
		n = amer_pkg::ZERO_TIME_US[code] * SAMPLE_RATE_HZ
			/ amer_pkg::US_PER_S;
		return CW'(n);
	endfunction

	function automatic logic [CW-1:0] zero_count(input logic [CW-1:0] c,
		input logic [SW-1:0] smp);
		if (smp != '0)
			return '0;
		return (&c) ? c : c + 1'b1;
	endfunction

	amer_fifo #(
		.WIDTH(2*SW),
		.DEPTH(amer_pkg::FIFO_DEPTH)
	) u_fifo (
		.clock(clock),
		.rst_n(rst_n),
		.in_valid(in_valid),
		.in_ready(in_ready),
		.in_data({in_left, in_right}),
		.out_valid(fifo_valid),
		.out_ready(pop),
		.out_data(fifo_data)
	);

	assign readdata = {24'h000000, s_reg.rdata};
	assign waitrequest = s_reg.wait_q;
	assign out_valid = s_reg.out_valid;
	assign out_left = s_reg.out_l;
	assign out_right = s_reg.out_r;
	assign mute_left = s_reg.mute_l;
	assign mute_right = s_reg.mute_r;
	assign volume_atten = s_reg.atten;
	assign class_d_bandwidth = s_reg.bw[amer_pkg::BW_LSB +: 2];
	assign output_attenuation = s_reg.gain[amer_pkg::GAIN_LSB +: 5];

	always_comb begin
		s_next = s_reg;
		idx = address[8:2];
		// --------------------------------------------------------
		// Register bus: one wait cycle, then a one-cycle answer
		// --------------------------------------------------------
		s_next.wait_q = 1'b1;
		if ((read || write) && s_reg.wait_q) begin
			s_next.wait_q = 1'b0;
			s_next.rdata = 8'h00;
			if (address[1:0] != 2'h0)
				s_next.rdata = 8'h00;
			else if (idx == amer_pkg::IDX_EMERG)
				s_next.rdata = s_reg.emerg;
			else if (idx == amer_pkg::IDX_MUTE_EN)
				s_next.rdata = s_reg.mute_en;
			else if (idx == amer_pkg::IDX_MUTE_DLY)
				s_next.rdata = s_reg.mute_dly;
			else if (idx == amer_pkg::IDX_BW)
				s_next.rdata = s_reg.bw;
			else if (idx == amer_pkg::IDX_GAIN)
				s_next.rdata = s_reg.gain;
			else if (idx == amer_pkg::IDX_STATE)
				s_next.rdata = {6'h00, s_reg.mute_r, s_reg.mute_l};
			else if (idx == amer_pkg::IDX_VOL)
				s_next.rdata = s_reg.atten;
		end
		// Whole bytes are stored, reserved bits included
		if (write && !s_reg.wait_q && byteenable[0] &&
			address[1:0] == 2'h0) begin
			if (idx == amer_pkg::IDX_EMERG)
				s_next.emerg = writedata[7:0];
			else if (idx == amer_pkg::IDX_MUTE_EN)
				s_next.mute_en = writedata[7:0];
			else if (idx == amer_pkg::IDX_MUTE_DLY)
				s_next.mute_dly = writedata[7:0];
			else if (idx == amer_pkg::IDX_BW)
				s_next.bw = writedata[7:0];
			else if (idx == amer_pkg::IDX_GAIN)
				s_next.gain = writedata[7:0];
		end
		// --------------------------------------------------------
		// Sample path: each pop is one sample period
		// --------------------------------------------------------
		pop = fifo_valid && (!s_reg.out_valid || out_ready);
		if (out_ready)
			s_next.out_valid = 1'b0;
		if (pop) begin
			s_next.cnt_l = zero_count(s_reg.cnt_l, fifo_data[2*SW-1:SW]);
			s_next.cnt_r = zero_count(s_reg.cnt_r, fifo_data[SW-1:0]);
		end
		qual_l = s_next.mute_en[amer_pkg::EN_LEFT_BIT] &&
			s_next.cnt_l >= zero_limit(
			s_next.mute_dly[amer_pkg::TIME_LEFT_LSB +: 3]);
		qual_r = s_next.mute_en[amer_pkg::EN_RIGHT_BIT] &&
			s_next.cnt_r >= zero_limit(
			s_next.mute_dly[amer_pkg::TIME_RIGHT_LSB +: 3]);
		if (s_next.mute_en[amer_pkg::LINK_BIT]) begin
			s_next.mute_l = qual_l && qual_r;
			s_next.mute_r = qual_l && qual_r;
		end else begin
			s_next.mute_l = qual_l;
			s_next.mute_r = qual_r;
		end
		if (pop) begin
			s_next.out_valid = 1'b1;
			s_next.out_l = s_next.mute_l ? '0 : fifo_data[2*SW-1:SW];
			s_next.out_r = s_next.mute_r ? '0 : fifo_data[SW-1:0];
		end
		// --------------------------------------------------------
		// Emergency ramp; atten returns to 00 at once when the emergency ends
		// --------------------------------------------------------
		emerg = clock_error || power_outage;
		rate = s_reg.emerg[amer_pkg::EMERG_RATE_LSB +: 2];
		step = amer_pkg::STEP_HALF_DB[
			s_reg.emerg[amer_pkg::EMERG_STEP_LSB +: 2]];
		sum = {1'b0, s_reg.atten} + {1'b0, step};
		if (!emerg) begin
			s_next.atten = 8'h00;
			s_next.rate_cnt = 2'h0;
		end else if (rate == amer_pkg::RATE_INSTANT) begin
			s_next.atten = amer_pkg::ATTEN_MUTE;
		end else if (pop) begin
			// Period is 1, 2 or 4 samples: last count is 2^rate - 1
			if (s_reg.rate_cnt >= 2'((1 << rate) - 1)) begin
				s_next.rate_cnt = 2'h0;
				s_next.atten = sum[8] || sum[7:0] == 8'hff ?
					amer_pkg::ATTEN_MUTE : sum[7:0];
			end else begin
				s_next.rate_cnt = s_reg.rate_cnt + 2'h1;
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s_reg <= '0;
			s_reg.emerg <= amer_pkg::RST_EMERG;
			s_reg.mute_en <= amer_pkg::RST_MUTE_EN;
			s_reg.mute_dly <= amer_pkg::RST_ZERO;
			s_reg.bw <= amer_pkg::RST_ZERO;
			s_reg.gain <= amer_pkg::RST_ZERO;
			s_reg.wait_q <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	sequence seq_ramp_tick;
		emerg && pop && s_reg.emerg[7:6] == 2'h0 && s_reg.atten < 8'hf0;
	endsequence
	sequence seq_bus_req;
		(read || write) && waitrequest;
	endsequence

	chk_instant_mute: assert property (
		emerg && s_reg.emerg[7:6] == 2'h3 |=> volume_atten == 8'hff)
		else $error("instant mute not applied");
	chk_ramp_step: assert property (
		seq_ramp_tick |=> volume_atten == $past(s_reg.atten) + $past(step))
		else $error("emergency step size wrong");
	chk_slow_rate: assert property (
		emerg && s_reg.emerg[7:6] == 2'h2 && pop && s_reg.rate_cnt == 2'h0
		|=> volume_atten == $past(s_reg.atten))
		else $error("ramp updated too often");
	chk_no_emerg: assert property (
		!emerg |=> volume_atten == 8'h00)
		else $error("volume ramped without emergency");
	chk_left_gate: assert property (
		mute_left |-> s_reg.mute_en[0])
		else $error("left muted while disabled");
	chk_right_gate: assert property (
		mute_right |-> s_reg.mute_en[1])
		else $error("right muted while disabled");
	chk_link_both: assert property (
		s_reg.mute_en[2] && mute_left |-> mute_right)
		else $error("linked channels muted apart");
	chk_left_delay: assert property (
		mute_left |-> s_reg.cnt_l >= zero_limit(s_reg.mute_dly[6:4]))
		else $error("left muted before zero run");
	chk_right_delay: assert property (
		mute_right |-> s_reg.cnt_r >= zero_limit(s_reg.mute_dly[2:0]))
		else $error("right muted before zero run");
	chk_zero_restart: assert property (
		pop && fifo_data[2*SW-1:SW] != '0 |=> s_reg.cnt_l == '0 && !mute_left)
		else $error("nonzero sample kept left muted");
	chk_bw_write: assert property (
		write && !waitrequest && byteenable[0] && address == 9'h14c
		|=> class_d_bandwidth == $past(writedata[6:5]))
		else $error("bandwidth field not stored");
	chk_bus_answer: assert property (
		seq_bus_req |=> !waitrequest ##1 waitrequest)
		else $error("bus answer not one cycle");
endmodule // amer_top

// >>> verif/amer_src_model.sv
// Sample source and sink facing the block's stream ports.
// Assumes one clock; the bench calls push, idle and fill.
`timescale 1ns/1ps
module amer_src_model #(
	parameter int unsigned SW = 24
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic in_ready,
	input wire logic out_valid,
	input wire logic [SW-1:0] out_left,
	input wire logic [SW-1:0] out_right,
	output logic in_valid,
	output logic [SW-1:0] in_left,
	output logic [SW-1:0] in_right,
	output logic out_ready
);
	logic stall = 1'b0;
	logic slow = 1'b1;
	int rx_count = 0;
	logic [SW-1:0] rx_left = '0;
	logic [SW-1:0] rx_right = '0;
	initial begin
		in_valid = 1'b0;
		in_left = '0;
		in_right = '0;
		out_ready = 1'b0;
	end
	// Slow mode halves the drain rate so the FIFO sees back pressure
	always @(posedge clock) begin
		out_ready <= !stall && (!slow || !out_ready);
	end
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rx_count <= 0;
		end else if (out_valid && out_ready) begin
			rx_count <= rx_count + 1;
			rx_left <= out_left;
			rx_right <= out_right;
		end
	end
	// Request held until in_ready is seen at an edge
	task automatic push(input logic [SW-1:0] l, input logic [SW-1:0] r);
		in_valid <= 1'b1;
		in_left <= l;
		in_right <= r;
		@(posedge clock);
		while (in_ready !== 1'b1) @(posedge clock);
	endtask
	// Released data is inverted so a stale word never looks valid
	task automatic idle();
		in_valid <= 1'b0;
		in_left <= ~in_left;
		in_right <= ~in_right;
	endtask
	task automatic fill(output int n);
		n = 0;
		stall <= 1'b1;
		push(24'h1, 24'h1);
		while (n < 40) begin
			@(posedge clock);
			if (in_ready !== 1'b1) break;
			n++;
		end
		stall <= 1'b0;
		while (in_ready !== 1'b1) @(posedge clock);
		idle();
	endtask
endmodule // amer_src_model

// >>> verif/tb_auto_mute_and_emergency_ramp.sv
// Self-checking bench for the auto mute and emergency ramp block.
// Assumes the design package is compiled first.
`timescale 1ns/1ps
module tb_auto_mute_and_emergency_ramp;
	localparam longint RATE = 1000;
	typedef struct {logic [6:0] idx; logic [7:0] rst, wr, rd;} amer_row_t;
	typedef struct {logic [7:0] cfg, exp;} amer_erow_t;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic [8:0] address = '0;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [31:0] writedata = '0;
	logic [31:0] readdata;
	logic waitrequest, in_valid, in_ready, out_valid, out_ready;
	logic [23:0] in_left, in_right, out_left, out_right;
	logic clock_error = 1'b0;
	logic power_outage = 1'b0;
	logic mute_left, mute_right;
	logic [7:0] volume_atten;
	logic [1:0] class_d_bandwidth;
	logic [4:0] output_attenuation;
	int num_errors = 0;
	int num_checks = 0;
	int cycles = 0;
	amer_row_t rows [7] = '{
		'{amer_pkg::IDX_EMERG, 8'h30, 8'hff, 8'hff},
		'{amer_pkg::IDX_MUTE_EN, 8'h07, 8'hf8, 8'hf8},
		'{amer_pkg::IDX_MUTE_DLY, 8'h00, 8'hff, 8'hff},
		'{amer_pkg::IDX_BW, 8'h00, 8'hff, 8'hff},
		'{amer_pkg::IDX_GAIN, 8'h00, 8'hff, 8'hff},
		'{7'h55, 8'h00, 8'haa, 8'h00},
		'{amer_pkg::IDX_VOL, 8'h00, 8'h12, 8'h00}};
	amer_erow_t erows [7] = '{'{8'h00, 8'h20}, '{8'h10, 8'h10},
		'{8'h20, 8'h08}, '{8'h30, 8'h04}, '{8'h70, 8'h02},
		'{8'hb0, 8'h01}, '{8'hc0, 8'hff}};
	always #20 clock = ~clock;
	amer_top #(.SAMPLE_RATE_HZ(RATE)) amer_top_i (.clock(clock),
		.rst_n(rst_n), .address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(4'h1), .readdata(readdata),
		.waitrequest(waitrequest), .in_valid(in_valid),
		.in_ready(in_ready), .in_left(in_left), .in_right(in_right),
		.out_valid(out_valid), .out_ready(out_ready),
		.out_left(out_left), .out_right(out_right),
		.clock_error(clock_error), .power_outage(power_outage),
		.mute_left(mute_left), .mute_right(mute_right),
		.volume_atten(volume_atten),
		.class_d_bandwidth(class_d_bandwidth),
		.output_attenuation(output_attenuation));
	amer_src_model amer_src_model_i (.clock(clock), .rst_n(rst_n),
		.in_ready(in_ready), .out_valid(out_valid), .out_left(out_left),
		.out_right(out_right), .in_valid(in_valid), .in_left(in_left),
		.in_right(in_right), .out_ready(out_ready));
	task automatic results();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			num_errors++;
			results();
		end
	end
	task automatic check(input string what, input logic [31:0] e,
		input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic bus(input logic [6:0] idx, input logic wr,
		input logic [7:0] wd, output logic [31:0] rd);
		address <= {idx, 2'b00};
		read <= !wr;
		write <= wr;
		writedata <= {24'h0, wd};
		@(posedge clock);
		while (waitrequest !== 1'b0) @(posedge clock);
		rd = readdata;
		read <= 1'b0;
		write <= 1'b0;
		@(posedge clock);
	endtask
	task automatic send(input int n, input logic [23:0] l,
		input logic [23:0] r);
		int target;
		target = amer_src_model_i.rx_count + n;
		repeat (n) amer_src_model_i.push(l, r);
		amer_src_model_i.idle();
		@(posedge clock);
		while (amer_src_model_i.rx_count < target) @(posedge clock);
		repeat (2) @(posedge clock);
	endtask
	initial begin
		logic [31:0] rd;
		int run0;
		int run1;
		int n;
		run0 = int'(amer_pkg::ZERO_TIME_US[0] * RATE / amer_pkg::US_PER_S);
		run1 = int'(amer_pkg::ZERO_TIME_US[1] * RATE / amer_pkg::US_PER_S);
		repeat (4) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		check("waitrequest", 32'h1, 32'(waitrequest));
		for (int i = 0; i < 7; i++) begin
			bus(rows[i].idx, 1'b0, 8'h00, rd);
			check("reset value", {24'h0, rows[i].rst}, rd);
			bus(rows[i].idx, 1'b1, rows[i].wr, rd);
			bus(rows[i].idx, 1'b0, 8'h00, rd);
			check("readback", {24'h0, rows[i].rd}, rd);
		end
		for (int c = 0; c < 4; c++) begin
			bus(amer_pkg::IDX_BW, 1'b1, 8'(c << 5), rd);
			check("bandwidth", 32'(c), 32'(class_d_bandwidth));
		end
		for (int c = 0; c < 32; c++) begin
			bus(amer_pkg::IDX_GAIN, 1'b1, 8'(c) | 8'he0, rd);
			check("gain", 32'(c), 32'(output_attenuation));
		end
		for (int i = 0; i < 7; i++) begin
			bus(amer_pkg::IDX_EMERG, 1'b1, erows[i].cfg, rd);
			clock_error <= i[0];
			power_outage <= !i[0];
			send(4, 24'h10, 24'h10);
			check("ramp", 32'(erows[i].exp), 32'(volume_atten));
			check("out left", 32'h10, 32'(amer_src_model_i.rx_left));
			clock_error <= 1'b0;
			power_outage <= 1'b0;
			repeat (2) @(posedge clock);
			check("recover", 32'h0, 32'(volume_atten));
		end
		// Stalled sink: fill until refused, then drain slowly
		amer_src_model_i.fill(n);
		check("fill depth", 32'h1, 32'(n == 16 || n == 17));
		// About eighteen words drain at half rate; allow ample time
		repeat (60) @(posedge clock);
		check("drained", 32'h2, {30'h0, in_ready, out_valid});
		bus(amer_pkg::IDX_MUTE_DLY, 1'b1, 8'h00, rd);
		bus(amer_pkg::IDX_MUTE_EN, 1'b1, 8'h07, rd);
		send(run0 + 2, 24'h0, 24'h5);
		check("linked left", 32'h0, 32'(mute_left));
		check("out right", 32'h5, 32'(amer_src_model_i.rx_right));
		bus(amer_pkg::IDX_MUTE_EN, 1'b1, 8'h03, rd);
		check("alone left", 32'h1, 32'(mute_left));
		send(1, 24'h5, 24'h0);
		check("unmute left", 32'h0, 32'(mute_left));
		bus(amer_pkg::IDX_MUTE_EN, 1'b1, 8'h02, rd);
		send(1, 24'h5, 24'h5);
		send(run0 - 1, 24'h0, 24'h0);
		check("early right", 32'h0, 32'(mute_right));
		send(2, 24'h0, 24'h0);
		check("mutes", 32'h1, {30'h0, mute_left, mute_right});
		bus(amer_pkg::IDX_MUTE_EN, 1'b1, 8'h05, rd);
		check("linked one", 32'h0, {30'h0, mute_left, mute_right});
		bus(amer_pkg::IDX_MUTE_EN, 1'b1, 8'h07, rd);
		check("linked both", 32'h3, {30'h0, mute_left, mute_right});
		bus(amer_pkg::IDX_MUTE_DLY, 1'b1, 8'h10, rd);
		bus(amer_pkg::IDX_MUTE_EN, 1'b1, 8'h01, rd);
		send(1, 24'h5, 24'h5);
		send(run1 - 1, 24'h0, 24'h0);
		check("left run", 32'h0, 32'(mute_left));
		send(2, 24'h0, 24'h0);
		bus(amer_pkg::IDX_STATE, 1'b0, 8'h00, rd);
		check("state", 32'h1, rd);
		// Second reset in mid-run
		rst_n <= 1'b0;
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		check("reset mute", 32'h0, 32'(mute_left));
		bus(amer_pkg::IDX_MUTE_EN, 1'b0, 8'h00, rd);
		check("reset enable", 32'h7, rd);
		results();
	end
endmodule // tb_auto_mute_and_emergency_ramp
